// ### hdl/iosad_io_space.sv
`timescale 1ns/10ps
`default_nettype none
module iosad_io_space (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic io_req_i,
	input wire logic io_we_i,
	input wire logic [5:0] io_addr_i,
	input wire logic [7:0] io_wdata_i,
	input wire logic ds_req_i,
	input wire logic ds_we_i,
	input wire logic [15:0] ds_addr_i,
	input wire logic [7:0] ds_wdata_i,
	input wire logic bit_req_i,
	input wire iosad_pkg::iosad_bit_op_type bit_op_i,
	input wire logic [4:0] bit_addr_i,
	input wire logic [2:0] bit_sel_i,
	input wire logic [7:0] pin_a_i,
	input wire logic [7:0] pin_b_i,
	input wire logic [7:0] pin_c_i,
	input wire logic [7:0] pin_d_i,
	input wire logic [7:0] timer0_evt_i,
	input wire logic [7:0] timer1_evt_i,
	input wire logic [7:0] timer2_evt_i,
	input wire logic [7:0] pin_change_evt_i,
	input wire logic [7:0] external_irq_evt_i,
	output logic done_o,
	output logic [7:0] rd_data_o,
	output logic skip_o,
	output logic ext_req_o,
	output logic ext_we_o,
	output logic [15:0] ext_addr_o,
	output logic [7:0] ext_wdata_o,
	output logic [7:0] port_a_out_o,
	output logic [7:0] port_a_dir_o,
	output logic [7:0] port_b_out_o,
	output logic [7:0] port_b_dir_o,
	output logic [7:0] port_c_out_o,
	output logic [7:0] port_c_dir_o,
	output logic [7:0] port_d_out_o,
	output logic [7:0] port_d_dir_o
);
	typedef struct packed {
		logic [63:0][7:0] regs;
		logic done;
		logic [7:0] rd_data;
		logic skip;
		logic ext_req;
		logic ext_we;
		logic [15:0] ext_addr;
		logic [7:0] ext_wdata;
	} iosad_state_type;

	iosad_state_type state;
	iosad_state_type next_state;

	logic hit;
	logic [5:0] idx;
	logic ext;
	logic is_bit;
	logic [7:0] cur;
	logic [7:0] bit_mask;
	logic wr_en;
	logic [7:0] wr_val;
	logic [4:0][7:0] evt_vec;
	logic [4:0][5:0] evt_ofs;

	// implemented bits per location; zero marks a reserved address
	function automatic logic [7:0] impl_mask(input logic [5:0] a);
		logic [7:0] m;
		m = 8'h00;
		if (a <= iosad_pkg::OFS_PORT_D_OUTPUT) begin
			m = iosad_pkg::MASK_FULL;
		end else if (a == iosad_pkg::OFS_TIMER0_FLAGS) begin
			m = iosad_pkg::MASK_TIMER0_FLAGS;
		end else if (a == iosad_pkg::OFS_TIMER1_FLAGS) begin
			m = iosad_pkg::MASK_TIMER1_FLAGS;
		end else if (a == iosad_pkg::OFS_TIMER2_FLAGS) begin
			m = iosad_pkg::MASK_TIMER2_FLAGS;
		end else if (a == iosad_pkg::OFS_PIN_CHANGE_FLAGS) begin
			m = iosad_pkg::MASK_PIN_CHANGE_FLAGS;
		end else if (a == iosad_pkg::OFS_EXTERNAL_IRQ_FLAGS) begin
			m = iosad_pkg::MASK_EXTERNAL_IRQ;
		end else if (a == iosad_pkg::OFS_EXTERNAL_IRQ_MASK) begin
			m = iosad_pkg::MASK_EXTERNAL_IRQ;
		end else if (a == iosad_pkg::OFS_GENERAL_PURPOSE_ZERO) begin
			m = iosad_pkg::MASK_FULL;
		end else if (a == iosad_pkg::OFS_EEPROM_CONTROL) begin
			m = iosad_pkg::MASK_EEPROM_CONTROL;
		end else if (a == iosad_pkg::OFS_EEPROM_DATA) begin
			m = iosad_pkg::MASK_FULL;
		end else if (a == iosad_pkg::OFS_EEPROM_ADDRESS_LOW) begin
			m = iosad_pkg::MASK_FULL;
		end else if (a == iosad_pkg::OFS_EEPROM_ADDRESS_HIGH) begin
			m = iosad_pkg::MASK_EEPROM_ADDRESS_HIGH;
		end else if (a == iosad_pkg::OFS_GENERAL_TIMER_CONTROL) begin
			m = iosad_pkg::MASK_GENERAL_TIMER_CONTROL;
		end else if (a == iosad_pkg::OFS_TIMER0_CONTROL_A) begin
			m = iosad_pkg::MASK_TIMER0_CONTROL_A;
		end else if (a == iosad_pkg::OFS_TIMER0_CONTROL_B) begin
			m = iosad_pkg::MASK_TIMER0_CONTROL_B;
		end else if (a == iosad_pkg::OFS_TIMER0_COUNT) begin
			m = iosad_pkg::MASK_FULL;
		end else if (a == iosad_pkg::OFS_TIMER0_COMPARE_A) begin
			m = iosad_pkg::MASK_FULL;
		end else if (a == iosad_pkg::OFS_TIMER0_COMPARE_B) begin
			m = iosad_pkg::MASK_FULL;
		end else if (a == iosad_pkg::OFS_GENERAL_PURPOSE_ONE) begin
			m = iosad_pkg::MASK_FULL;
		end else if (a == iosad_pkg::OFS_GENERAL_PURPOSE_TWO) begin
			m = iosad_pkg::MASK_FULL;
		end else if (a == iosad_pkg::OFS_SERIAL_PERIPH_CONTROL) begin
			m = iosad_pkg::MASK_FULL;
		end else if (a == iosad_pkg::OFS_SERIAL_PERIPH_STATUS) begin
			m = iosad_pkg::MASK_SERIAL_PERIPH_STATUS;
		end else if (a == iosad_pkg::OFS_SERIAL_PERIPH_DATA) begin
			m = iosad_pkg::MASK_FULL;
		end else if (a == iosad_pkg::OFS_COMPARATOR_CONTROL) begin
			m = iosad_pkg::MASK_FULL;
		end else if (a == iosad_pkg::OFS_DEBUG_DATA) begin
			m = iosad_pkg::MASK_FULL;
		end else if (a == iosad_pkg::OFS_SLEEP_CONTROL) begin
			m = iosad_pkg::MASK_SLEEP_CONTROL;
		end else if (a == iosad_pkg::OFS_RESET_CAUSE) begin
			m = iosad_pkg::MASK_RESET_CAUSE;
		end else if (a == iosad_pkg::OFS_CORE_CONTROL) begin
			m = iosad_pkg::MASK_CORE_CONTROL;
		end else if (a == iosad_pkg::OFS_SELF_PROGRAM_CONTROL) begin
			m = iosad_pkg::MASK_FULL;
		end else if (a >= iosad_pkg::OFS_STACK_POINTER_LOW) begin
			m = iosad_pkg::MASK_FULL;
		end
		return m;
	endfunction

	// input registers mirror the pins and are never stored
	function automatic logic is_pin_reg(input logic [5:0] a);
		return a == iosad_pkg::OFS_PORT_A_INPUT || a == iosad_pkg::OFS_PORT_B_INPUT
			|| a == iosad_pkg::OFS_PORT_C_INPUT || a == iosad_pkg::OFS_PORT_D_INPUT;
	endfunction

	function automatic logic is_w1c_reg(input logic [5:0] a);
		return a == iosad_pkg::OFS_TIMER0_FLAGS || a == iosad_pkg::OFS_TIMER1_FLAGS
			|| a == iosad_pkg::OFS_TIMER2_FLAGS || a == iosad_pkg::OFS_PIN_CHANGE_FLAGS
			|| a == iosad_pkg::OFS_EXTERNAL_IRQ_FLAGS;
	endfunction

	iosad_addr_map u_map (
		.io_req_i(io_req_i),
		.io_addr_i(io_addr_i),
		.ds_req_i(ds_req_i),
		.ds_addr_i(ds_addr_i),
		.bit_req_i(bit_req_i),
		.bit_addr_i(bit_addr_i),
		.hit_o(hit),
		.idx_o(idx),
		.ext_o(ext),
		.bit_o(is_bit)
	);

	assign evt_vec[0] = timer0_evt_i;
	assign evt_vec[1] = timer1_evt_i;
	assign evt_vec[2] = timer2_evt_i;
	assign evt_vec[3] = pin_change_evt_i;
	assign evt_vec[4] = external_irq_evt_i;
	assign evt_ofs[0] = iosad_pkg::OFS_TIMER0_FLAGS;
	assign evt_ofs[1] = iosad_pkg::OFS_TIMER1_FLAGS;
	assign evt_ofs[2] = iosad_pkg::OFS_TIMER2_FLAGS;
	assign evt_ofs[3] = iosad_pkg::OFS_PIN_CHANGE_FLAGS;
	assign evt_ofs[4] = iosad_pkg::OFS_EXTERNAL_IRQ_FLAGS;

	// current value of the addressed location, reserved bits forced low
	always_comb begin
		if (idx == iosad_pkg::OFS_PORT_A_INPUT) begin
			cur = pin_a_i;
		end else if (idx == iosad_pkg::OFS_PORT_B_INPUT) begin
			cur = pin_b_i;
		end else if (idx == iosad_pkg::OFS_PORT_C_INPUT) begin
			cur = pin_c_i;
		end else if (idx == iosad_pkg::OFS_PORT_D_INPUT) begin
			cur = pin_d_i;
		end else begin
			cur = state.regs[idx] & impl_mask(idx);
		end
	end

	assign bit_mask = 8'h01 << bit_sel_i;

	// write value; a bit instruction rebuilds the whole byte from its read
	always_comb begin
		wr_en = 1'b0;
		wr_val = 8'h00;
		if (hit && !is_bit) begin
			wr_en = io_req_i ? io_we_i : ds_we_i;
			wr_val = io_req_i ? io_wdata_i : ds_wdata_i;
		end else if (is_bit) begin
			if (bit_op_i == iosad_pkg::BIT_OP_SET) begin
				wr_en = 1'b1;
				wr_val = cur | bit_mask;
			end else if (bit_op_i == iosad_pkg::BIT_OP_CLEAR) begin
				wr_en = 1'b1;
				wr_val = cur & ~bit_mask;
			end
		end
	end

	always_comb begin
		next_state = state;
		next_state.done = 1'b0;
		next_state.skip = 1'b0;
		next_state.ext_req = 1'b0;
		next_state.ext_we = 1'b0;
		if (hit) begin
			next_state.done = 1'b1;
			next_state.rd_data = cur;
		end
		if (is_bit) begin
			if (bit_op_i == iosad_pkg::BIT_OP_SKIP_SET) begin
				next_state.skip = (cur & bit_mask) != 8'h00;
			end else if (bit_op_i == iosad_pkg::BIT_OP_SKIP_CLEAR) begin
				next_state.skip = (cur & bit_mask) == 8'h00;
			end
		end
		if (ext) begin
			// forwarded unchanged; the extended space owner answers for itself
			next_state.ext_req = 1'b1;
			next_state.ext_we = ds_we_i;
			next_state.ext_addr = ds_addr_i;
			next_state.ext_wdata = ds_wdata_i;
		end
		if (wr_en && !is_pin_reg(idx)) begin
			if (is_w1c_reg(idx)) begin
				// ones clear, zeros keep
				next_state.regs[idx] = state.regs[idx] & ~(wr_val & impl_mask(idx));
			end else begin
				next_state.regs[idx] = wr_val & impl_mask(idx);
			end
		end
		// hardware sets land after the clear so a same-cycle event survives
		for (int k = 0; k < 5; k++) begin
			next_state.regs[evt_ofs[k]] = next_state.regs[evt_ofs[k]]
				| (evt_vec[k] & impl_mask(evt_ofs[k]));
		end
		if (srst_i) begin
			next_state = '0;
			for (int k = 0; k < iosad_pkg::IO_LOCATIONS; k++) begin
				next_state.regs[k] = iosad_pkg::REG_RESET;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		state <= next_state;
	end

	assign done_o = state.done;
	assign rd_data_o = state.rd_data;
	assign skip_o = state.skip;
	assign ext_req_o = state.ext_req;
	assign ext_we_o = state.ext_we;
	assign ext_addr_o = state.ext_addr;
	assign ext_wdata_o = state.ext_wdata;
	assign port_a_out_o = state.regs[iosad_pkg::OFS_PORT_A_OUTPUT];
	assign port_a_dir_o = state.regs[iosad_pkg::OFS_PORT_A_DIRECTION];
	assign port_b_out_o = state.regs[iosad_pkg::OFS_PORT_B_OUTPUT];
	assign port_b_dir_o = state.regs[iosad_pkg::OFS_PORT_B_DIRECTION];
	assign port_c_out_o = state.regs[iosad_pkg::OFS_PORT_C_OUTPUT];
	assign port_c_dir_o = state.regs[iosad_pkg::OFS_PORT_C_DIRECTION];
	assign port_d_out_o = state.regs[iosad_pkg::OFS_PORT_D_OUTPUT];
	assign port_d_dir_o = state.regs[iosad_pkg::OFS_PORT_D_DIRECTION];

endmodule // iosad_io_space
`default_nettype wire

// ### hdl/iosad_pkg.sv
package iosad_pkg;

	// io space geometry
	localparam int IO_LOCATIONS = 64;
	localparam logic [5:0] IO_BIT_TOP = 6'h1f;
	localparam logic [15:0] DS_IO_OFFSET = 16'h0020;
	localparam logic [15:0] DS_EXT_BASE = 16'h0060;
	localparam logic [7:0] REG_RESET = 8'h00;

	// register offsets in io space
	localparam logic [5:0] OFS_PORT_A_INPUT = 6'h00;
	localparam logic [5:0] OFS_PORT_A_DIRECTION = 6'h01;
	localparam logic [5:0] OFS_PORT_A_OUTPUT = 6'h02;
	localparam logic [5:0] OFS_PORT_B_INPUT = 6'h03;
	localparam logic [5:0] OFS_PORT_B_DIRECTION = 6'h04;
	localparam logic [5:0] OFS_PORT_B_OUTPUT = 6'h05;
	localparam logic [5:0] OFS_PORT_C_INPUT = 6'h06;
	localparam logic [5:0] OFS_PORT_C_DIRECTION = 6'h07;
	localparam logic [5:0] OFS_PORT_C_OUTPUT = 6'h08;
	localparam logic [5:0] OFS_PORT_D_INPUT = 6'h09;
	localparam logic [5:0] OFS_PORT_D_DIRECTION = 6'h0a;
	localparam logic [5:0] OFS_PORT_D_OUTPUT = 6'h0b;
	localparam logic [5:0] OFS_TIMER0_FLAGS = 6'h15;
	localparam logic [5:0] OFS_TIMER1_FLAGS = 6'h16;
	localparam logic [5:0] OFS_TIMER2_FLAGS = 6'h17;
	localparam logic [5:0] OFS_PIN_CHANGE_FLAGS = 6'h1b;
	localparam logic [5:0] OFS_EXTERNAL_IRQ_FLAGS = 6'h1c;
	localparam logic [5:0] OFS_EXTERNAL_IRQ_MASK = 6'h1d;
	localparam logic [5:0] OFS_GENERAL_PURPOSE_ZERO = 6'h1e;
	localparam logic [5:0] OFS_EEPROM_CONTROL = 6'h1f;
	localparam logic [5:0] OFS_EEPROM_DATA = 6'h20;
	localparam logic [5:0] OFS_EEPROM_ADDRESS_LOW = 6'h21;
	localparam logic [5:0] OFS_EEPROM_ADDRESS_HIGH = 6'h22;
	localparam logic [5:0] OFS_GENERAL_TIMER_CONTROL = 6'h23;
	localparam logic [5:0] OFS_TIMER0_CONTROL_A = 6'h24;
	localparam logic [5:0] OFS_TIMER0_CONTROL_B = 6'h25;
	localparam logic [5:0] OFS_TIMER0_COUNT = 6'h26;
	localparam logic [5:0] OFS_TIMER0_COMPARE_A = 6'h27;
	localparam logic [5:0] OFS_TIMER0_COMPARE_B = 6'h28;
	localparam logic [5:0] OFS_GENERAL_PURPOSE_ONE = 6'h2a;
	localparam logic [5:0] OFS_GENERAL_PURPOSE_TWO = 6'h2b;
	localparam logic [5:0] OFS_SERIAL_PERIPH_CONTROL = 6'h2c;
	localparam logic [5:0] OFS_SERIAL_PERIPH_STATUS = 6'h2d;
	localparam logic [5:0] OFS_SERIAL_PERIPH_DATA = 6'h2e;
	localparam logic [5:0] OFS_COMPARATOR_CONTROL = 6'h30;
	localparam logic [5:0] OFS_DEBUG_DATA = 6'h31;
	localparam logic [5:0] OFS_SLEEP_CONTROL = 6'h33;
	localparam logic [5:0] OFS_RESET_CAUSE = 6'h34;
	localparam logic [5:0] OFS_CORE_CONTROL = 6'h35;
	localparam logic [5:0] OFS_SELF_PROGRAM_CONTROL = 6'h37;
	localparam logic [5:0] OFS_STACK_POINTER_LOW = 6'h3d;
	localparam logic [5:0] OFS_STACK_POINTER_HIGH = 6'h3e;
	localparam logic [5:0] OFS_CORE_STATUS_FLAGS = 6'h3f;

	// implemented bits of the registers with reserved positions
	localparam logic [7:0] MASK_FULL = 8'hff;
	localparam logic [7:0] MASK_TIMER0_FLAGS = 8'h07;
	localparam logic [7:0] MASK_TIMER1_FLAGS = 8'h27;
	localparam logic [7:0] MASK_TIMER2_FLAGS = 8'h07;
	localparam logic [7:0] MASK_PIN_CHANGE_FLAGS = 8'h0f;
	localparam logic [7:0] MASK_EXTERNAL_IRQ = 8'h07;
	localparam logic [7:0] MASK_EEPROM_CONTROL = 8'h3f;
	localparam logic [7:0] MASK_EEPROM_ADDRESS_HIGH = 8'h07;
	localparam logic [7:0] MASK_GENERAL_TIMER_CONTROL = 8'h83;
	localparam logic [7:0] MASK_TIMER0_CONTROL_A = 8'hf3;
	localparam logic [7:0] MASK_TIMER0_CONTROL_B = 8'hcf;
	localparam logic [7:0] MASK_SERIAL_PERIPH_STATUS = 8'hc1;
	localparam logic [7:0] MASK_SLEEP_CONTROL = 8'h0f;
	localparam logic [7:0] MASK_RESET_CAUSE = 8'h1f;
	localparam logic [7:0] MASK_CORE_CONTROL = 8'h93;

	// bit instruction codes
	typedef enum logic [1:0] {
		BIT_OP_SET = 2'h0,
		BIT_OP_CLEAR = 2'h1,
		BIT_OP_SKIP_SET = 2'h2,
		BIT_OP_SKIP_CLEAR = 2'h3
	} iosad_bit_op_type;

endpackage

// ### hdl/iosad_addr_map.sv
`timescale 1ns/10ps
`default_nettype none
module iosad_addr_map (
	input wire logic io_req_i,
	input wire logic [5:0] io_addr_i,
	input wire logic ds_req_i,
	input wire logic [15:0] ds_addr_i,
	input wire logic bit_req_i,
	input wire logic [4:0] bit_addr_i,
	output logic hit_o,
	output logic [5:0] idx_o,
	output logic ext_o,
	output logic bit_o
);
	logic [15:0] ds_rel;

	assign ds_rel = ds_addr_i - iosad_pkg::DS_IO_OFFSET;

	// fixed priority: io instruction, then load/store, then bit instruction
	always_comb begin
		hit_o = 1'b0;
		idx_o = 6'h00;
		ext_o = 1'b0;
		bit_o = 1'b0;
		if (io_req_i) begin
			hit_o = 1'b1;
			idx_o = io_addr_i;
		end else if (ds_req_i) begin
			if (ds_addr_i >= iosad_pkg::DS_IO_OFFSET && ds_addr_i < iosad_pkg::DS_EXT_BASE) begin
				hit_o = 1'b1;
				idx_o = ds_rel[5:0];
			end else if (ds_addr_i >= iosad_pkg::DS_EXT_BASE) begin
				ext_o = 1'b1;
			end
		end else if (bit_req_i) begin
			hit_o = 1'b1;
			bit_o = 1'b1;
			// a 5-bit operand cannot leave the low 32 locations
			idx_o = {1'b0, bit_addr_i};
		end
	end
endmodule // iosad_addr_map
`default_nettype wire

// ### test/iosad_io_space_props.sv
`timescale 1ns/10ps
`default_nettype none
module iosad_io_space_props (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic io_req_i,
	input wire logic io_we_i,
	input wire logic [5:0] io_addr_i,
	input wire logic [7:0] io_wdata_i,
	input wire logic ds_req_i,
	input wire logic [15:0] ds_addr_i,
	input wire logic bit_req_i,
	input wire iosad_pkg::iosad_bit_op_type bit_op_i,
	input wire logic [4:0] bit_addr_i,
	input wire logic [2:0] bit_sel_i,
	input wire logic done_o,
	input wire logic [7:0] rd_data_o,
	input wire logic skip_o,
	input wire logic ext_req_o,
	input wire logic [15:0] ext_addr_o,
	input wire logic [7:0] port_a_out_o,
	input wire logic [7:0] port_a_dir_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);
	// lower groups lose to io in the same cycle, so qualify them
	logic ds_go;
	logic bit_go;
	assign ds_go = ds_req_i && !io_req_i;
	assign bit_go = bit_req_i && !io_req_i && !ds_req_i;

	a_io_answer:
		assert property (io_req_i |=> done_o) else $error("io access not answered");
	a_io_port_write:
		assert property (io_req_i && io_we_i && io_addr_i == 6'h02
			|=> port_a_out_o == $past(io_wdata_i)) else $error("port a output not written");
	a_ds_low_silent:
		assert property (ds_go && ds_addr_i < 16'h0020 |=> !done_o && !ext_req_o)
			else $error("low data address answered");
	a_ext_forward:
		assert property (ds_go && ds_addr_i >= 16'h0060
			|=> ext_req_o && ext_addr_o == $past(ds_addr_i)) else $error("ext access lost");
	a_ext_cause:
		assert property (ext_req_o |-> $past(ds_go) && $past(ds_addr_i) >= 16'h0060)
			else $error("ext access without load or store");
	a_bit_set:
		assert property (bit_go && bit_op_i == iosad_pkg::BIT_OP_SET && bit_addr_i == 5'h01
			|=> port_a_dir_o == ($past(port_a_dir_o) | (8'h01 << $past(bit_sel_i))))
			else $error("bit set wrong");
	a_skip_cause:
		assert property (skip_o |-> $past(bit_go) && $past(bit_op_i) >= iosad_pkg::BIT_OP_SKIP_SET)
			else $error("skip without skip op");
	a_bit_answer:
		assert property (bit_go |=> done_o) else $error("bit access not answered");
	a_reserved_read:
		assert property (io_req_i && !io_we_i && io_addr_i == 6'h0c |=> rd_data_o == 8'h00)
			else $error("reserved location not zero");
endmodule // iosad_io_space_props

bind iosad_io_space iosad_io_space_props u_props (.clk_i, .srst_i, .io_req_i, .io_we_i,
	.io_addr_i, .io_wdata_i, .ds_req_i, .ds_addr_i, .bit_req_i, .bit_op_i, .bit_addr_i,
	.bit_sel_i, .done_o, .rd_data_o, .skip_o, .ext_req_o, .ext_addr_o, .port_a_out_o,
	.port_a_dir_o);
`default_nettype wire

// ### test/iosad_core_model.sv
`timescale 1ns/10ps
`default_nettype none
module iosad_core_model (
	input wire logic clk_i,
	input wire logic done_i,
	input wire logic skip_i,
	input wire logic ext_req_i,
	input wire logic [7:0] rd_data_i,
	output logic io_req_o,
	output logic io_we_o,
	output logic [5:0] io_addr_o,
	output logic [7:0] io_wdata_o,
	output logic ds_req_o,
	output logic ds_we_o,
	output logic [15:0] ds_addr_o,
	output logic [7:0] ds_wdata_o,
	output logic bit_req_o,
	output var iosad_pkg::iosad_bit_op_type bit_op_o,
	output logic [4:0] bit_addr_o,
	output logic [2:0] bit_sel_o
);
	initial begin
		{io_req_o, io_we_o, ds_req_o, ds_we_o, bit_req_o} = 5'h00;
		{io_addr_o, ds_addr_o, bit_addr_o, bit_sel_o} = 30'h0;
		{io_wdata_o, ds_wdata_o} = 16'h0000;
		bit_op_o = iosad_pkg::BIT_OP_SET;
	end
	// one instruction per call, held across exactly one taking edge
	task automatic access(input int kind, input logic we, input logic [15:0] addr,
		input logic [7:0] wd, input logic [1:0] op, input logic [2:0] sel,
		output logic [7:0] rd, output logic dn, output logic sk, output logic ex);
		@(negedge clk_i);
		{io_we_o, ds_we_o} = {we, we};
		io_addr_o = addr[5:0];
		bit_addr_o = addr[4:0];
		ds_addr_o = addr;
		{io_wdata_o, ds_wdata_o} = {wd, wd};
		bit_op_o = iosad_pkg::iosad_bit_op_type'(op);
		bit_sel_o = sel;
		{io_req_o, ds_req_o, bit_req_o} = {kind == 0, kind == 1, kind == 2};
		@(negedge clk_i);
		{rd, dn, sk, ex} = {rd_data_i, done_i, skip_i, ext_req_i};
		{io_req_o, ds_req_o, bit_req_o} = 3'h0;
		// released lines flip so a stale value never passes for a fresh one
		{io_addr_o, ds_addr_o, bit_addr_o, bit_sel_o} =
			~{io_addr_o, ds_addr_o, bit_addr_o, bit_sel_o};
		{io_wdata_o, ds_wdata_o} = ~{io_wdata_o, ds_wdata_o};
	endtask
endmodule // iosad_core_model
`default_nettype wire

// ### test/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
	localparam int K_IO = 0;
	localparam int K_DS = 1;
	localparam int K_BIT = 2;
	logic clk_i, srst_i, io_req_i, io_we_i, ds_req_i, ds_we_i, bit_req_i;
	logic [5:0] io_addr_i;
	logic [15:0] ds_addr_i, ext_addr_o;
	logic [7:0] io_wdata_i, ds_wdata_i, pin_a_i, pin_b_i, pin_c_i, pin_d_i, rd;
	logic [7:0] timer0_evt_i, timer1_evt_i, timer2_evt_i, pin_change_evt_i, external_irq_evt_i;
	iosad_pkg::iosad_bit_op_type bit_op_i;
	logic [4:0] bit_addr_i;
	logic [2:0] bit_sel_i;
	logic done_o, skip_o, ext_req_o, ext_we_o, dn, sk, ex;
	logic [7:0] rd_data_o, ext_wdata_o, port_a_out_o, port_a_dir_o, port_b_out_o, port_b_dir_o;
	logic [7:0] port_c_out_o, port_c_dir_o, port_d_out_o, port_d_dir_o;
	int failures = 0;
	int cmp_count = 0;

	iosad_io_space uut (.clk_i, .srst_i, .io_req_i, .io_we_i, .io_addr_i, .io_wdata_i, .ds_req_i,
		.ds_we_i, .ds_addr_i, .ds_wdata_i, .bit_req_i, .bit_op_i, .bit_addr_i, .bit_sel_i,
		.pin_a_i, .pin_b_i, .pin_c_i, .pin_d_i, .timer0_evt_i, .timer1_evt_i, .timer2_evt_i,
		.pin_change_evt_i, .external_irq_evt_i, .done_o, .rd_data_o, .skip_o, .ext_req_o,
		.ext_we_o, .ext_addr_o, .ext_wdata_o, .port_a_out_o, .port_a_dir_o, .port_b_out_o,
		.port_b_dir_o, .port_c_out_o, .port_c_dir_o, .port_d_out_o, .port_d_dir_o);
	iosad_core_model core (.clk_i, .done_i(done_o), .skip_i(skip_o), .ext_req_i(ext_req_o),
		.rd_data_i(rd_data_o), .io_req_o(io_req_i), .io_we_o(io_we_i), .io_addr_o(io_addr_i),
		.io_wdata_o(io_wdata_i), .ds_req_o(ds_req_i), .ds_we_o(ds_we_i), .ds_addr_o(ds_addr_i),
		.ds_wdata_o(ds_wdata_i), .bit_req_o(bit_req_i), .bit_op_o(bit_op_i),
		.bit_addr_o(bit_addr_i), .bit_sel_o(bit_sel_i));

	initial begin
		clk_i = 1'h0;
		forever #5 clk_i = ~clk_i;
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("FAIL %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic acc(input int k, input logic w, input logic [15:0] a, input logic [7:0] d,
		input logic [1:0] op = 2'h0, input logic [2:0] s = 3'h0);
		core.access(k, w, a, d, op, s, rd, dn, sk, ex);
	endtask
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic t_maps();
		logic [5:0] a[6] = '{6'h01, 6'h02, 6'h1d, 6'h22, 6'h35, 6'h3f};
		logic [7:0] m[6] = '{8'hff, 8'hff, 8'h07, 8'h07, 8'h93, 8'hff};
		for (int i = 0; i < 6; i++) begin
			acc(K_IO, 1'h1, 16'(a[i]), 8'hff);
			acc(K_DS, 1'h0, 16'(a[i]) + 16'h0020, 8'h00);
			check(rd, m[i]);
			acc(K_DS, 1'h1, 16'(a[i]) + 16'h0020, 8'h5a & m[i]);
			acc(K_IO, 1'h0, 16'(a[i]), 8'h00);
			check(rd, 8'h5a & m[i]);
			check(dn, 1'h1);
		end
		check(port_a_out_o, 8'h5a);
	endtask
	task automatic t_reserved();
		pin_a_i = 8'ha5;
		// the input registers 0x06 and 0x09 are skipped; the reserved 0x0c is only read
		for (int i = 4; i < 12; i++) begin
			if (i % 3 != 0) begin
				acc(K_IO, 1'h1, 16'(i), 8'(i) ^ 8'h3c);
			end
		end
		check({port_b_dir_o, port_b_out_o}, 16'h3839);
		check({port_c_dir_o, port_c_out_o}, 16'h3b34);
		check({port_d_dir_o, port_d_out_o}, 16'h3637);
		acc(K_IO, 1'h0, 16'h000c, 8'h00);
		check(rd, 8'h00);
		acc(K_IO, 1'h1, 16'h0000, 8'h00);
		acc(K_DS, 1'h0, 16'h0020, 8'h00);
		check(rd, 8'ha5);
	endtask
	task automatic t_bits();
		pin_b_i = 8'h10;
		acc(K_BIT, 1'h0, 16'h0001, 8'h00, 2'h0, 3'h7);
		check({sk, port_a_dir_o}, 9'h0da);
		check(dn, 1'h1);
		acc(K_BIT, 1'h0, 16'h0001, 8'h00, 2'h1, 3'h1);
		check(port_a_dir_o, 8'hd8);
		acc(K_BIT, 1'h0, 16'h001f, 8'h00, 2'h0, 3'h5);
		acc(K_IO, 1'h0, 16'h001f, 8'h00);
		check(rd, 8'h20);
		for (int i = 0; i < 4; i++) begin
			acc(K_BIT, 1'h0, 16'h0003, 8'h00, 2'h2 + 2'(i[0]), 3'h4 + 3'(i[1]));
			check(sk, (i[0] == 0) == (i[1] == 0));
		end
	endtask
	task automatic t_w1c();
		timer0_evt_i = 8'hff;
		external_irq_evt_i = 8'hff;
		@(negedge clk_i);
		{timer0_evt_i, external_irq_evt_i} = 16'h0000;
		acc(K_IO, 1'h1, 16'h0015, 8'h02);
		check(rd, 8'h07);
		acc(K_IO, 1'h1, 16'h0015, 8'h00);
		acc(K_IO, 1'h0, 16'h0015, 8'h00);
		check(rd, 8'h05);
		acc(K_BIT, 1'h0, 16'h0015, 8'h00, 2'h0, 3'h1);
		acc(K_IO, 1'h0, 16'h0015, 8'h00);
		check(rd, 8'h00);
		acc(K_BIT, 1'h0, 16'h001c, 8'h00, 2'h1, 3'h0);
		acc(K_DS, 1'h0, 16'h003c, 8'h00);
		check(rd, 8'h01);
	endtask
	task automatic t_ext();
		acc(K_DS, 1'h1, 16'h0060, 8'h3c);
		check({ex, ext_we_o, ext_wdata_o}, 10'h33c);
		check(ext_addr_o, 16'h0060);
		acc(K_DS, 1'h0, 16'hffff, 8'h00);
		check({ex, ext_we_o, ext_addr_o[7:0]}, 10'h2ff);
		acc(K_DS, 1'h0, 16'h001f, 8'h00);
		check({dn, ex}, 2'h0);
	endtask
	task automatic t_reset();
		srst_i = 1'h1;
		repeat (2) @(negedge clk_i);
		srst_i = 1'h0;
		check({port_a_out_o, port_a_dir_o}, 16'h0000);
		acc(K_IO, 1'h0, 16'h001c, 8'h00);
		check(rd, 8'h00);
	endtask

	initial begin
		srst_i = 1'h1;
		{pin_a_i, pin_b_i, pin_c_i, pin_d_i} = 32'h0000_0000;
		{timer0_evt_i, timer1_evt_i, timer2_evt_i, pin_change_evt_i, external_irq_evt_i} = 40'h0;
		repeat (4) @(negedge clk_i);
		srst_i = 1'h0;
		t_maps();
		t_reserved();
		t_bits();
		t_w1c();
		t_ext();
		t_reset();
		finish_test();
	end
	// whole run needs about a microsecond; this bound only catches a hang
	initial begin
		#50us;
		failures++;
		finish_test();
	end
endmodule // testbench
`default_nettype wire
